// ===== foagc_pkg.sv
// shared constants and types for the fail-output / alternate gpio control block
package foagc_pkg;

  localparam int          CLK_HZ          = 100_000_000;
  localparam int          BLINK_FREQ_MHZ  = 1250;
  localparam int          PULSE_FREQ_HZ   = 100;
  localparam int          STRAP_FILT_US   = 64;
  localparam int          WAKE_FILT_US    = 16;
  localparam int          BLINK_CYC       = int'(64'(CLK_HZ) * 64'd1000 / 64'(BLINK_FREQ_MHZ));
  localparam int          PULSE_CYC       = CLK_HZ / PULSE_FREQ_HZ;
  localparam int          STRAP_FILT_CYC  = STRAP_FILT_US * (CLK_HZ / 1_000_000);
  localparam int          WAKE_FILT_CYC   = WAKE_FILT_US * (CLK_HZ / 1_000_000);
  localparam int          DUTY_PERMIL_20  = 200;
  localparam int          DUTY_PERMIL_10  = 100;
  localparam int          DUTY_PERMIL_5   = 50;
  localparam int          DUTY_PERMIL_2P5 = 25;
  localparam int          PERMIL          = 1000;

  localparam int          ADDR_W          = 12;
  localparam logic [11:0] CTRL_OFS        = 12'h000;
  localparam logic [11:0] STAT_OFS        = 12'h004;
  localparam logic [11:0] MASK_OFS        = 12'h008;
  localparam logic [11:0] LVL_OFS         = 12'h00C;

  localparam int          CTRL_BLINK_LSB  = 0;
  localparam int          CTRL_PULSE_LSB  = 4;
  localparam int          CTRL_DUTY_LSB   = 8;
  localparam int          CTRL_FORCE_BIT  = 12;
  localparam int          CTRL_FCLR_BIT   = 13;
  localparam int          LVL_STRAP_BIT   = 2;
  localparam int          LVL_FAIL_BIT    = 3;

  typedef enum logic [2:0] {
    MODE_INIT     = 3'h0,
    MODE_NORMAL   = 3'h1,
    MODE_STOP     = 3'h3,
    MODE_SLEEP    = 3'h2,
    MODE_RESTART  = 3'h6,
    MODE_FAILSAFE = 3'h7
  } foagc_mode_t;

  typedef enum logic [2:0] {
    FN_FAIL = 3'h0,
    FN_OFF  = 3'h1,
    FN_WAKE = 3'h3,
    FN_LS   = 3'h2,
    FN_HS   = 3'h6
  } foagc_fn_t;

  localparam foagc_fn_t   FN_RESET        = FN_FAIL;
  localparam logic [1:0]  DUTY_RESET      = 2'h0;

  typedef struct packed {
    logic out;
    logic oe;
  } foagc_drive_t;

endpackage : foagc_pkg

// ===== foagc_filter.sv
// level filter: output follows the input once it has been stable for CNT cycles
`timescale 1ns/10ps
module foagc_filter #(
  parameter int   CNT   = 6400,
  parameter logic INIT  = 1'b1
) (
  input  wire logic CLOCK,
  input  wire logic RESET,
  input  wire logic din,
  output logic      q
);
  localparam int W = $clog2(CNT + 1);

  logic [W-1:0] cnt_r;

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      cnt_r <= '0;
      q     <= INIT;
    end
    else if (din == q)
    begin
      cnt_r <= '0;
    end
    else if (cnt_r == W'(CNT - 1))
    begin
      cnt_r <= '0;
      q     <= din;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule : foagc_filter

// ===== foagc_pwm.sv
// free-running period counter with an active phase of on_cyc cycles
`timescale 1ns/10ps
module foagc_pwm #(
  parameter int PERIOD = 1_000_000,
  parameter int W      = $clog2(PERIOD + 1)
) (
  input  wire logic         CLOCK,
  input  wire logic         RESET,
  input  wire logic         run,
  input  wire logic [W-1:0] on_cyc,
  output logic              active
);
  logic [W-1:0] cnt_r;

  // counter restarts from zero each time the output is enabled, so the first
  // active phase is always a full one
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
      cnt_r <= '0;
    else if (!run || cnt_r == W'(PERIOD - 1))
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + 1'b1;
  end

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
      active <= 1'b0;
    else
      active <= run && (cnt_r < on_cyc);
  end

endmodule : foagc_pwm

// ===== foagc_top.sv
// fail-output pins with alternate gpio functions, apb register access
`timescale 1ns/10ps

// Summary of operation
// - after reset both pins are fail outputs; only register writes change that
// - wake-input pins detect wake events and latch them in wake_status_second
// - low-side function drives the pin low; only level feedback reported
// - high-side function drives the pin high from highside_supply; no diagnosis
// - in Normal and Stop, gpio/LS/HS pin levels appear in wake_level_status
// - pin function settings change only in Normal mode
// - Stop and Sleep keep configured settings; wake pins stay wake capable
// - wake pins stay capable in Restart, off in Fail-Safe, config kept
// - LS/HS pins are off in Restart and Fail-Safe, config kept
// - a failure causing Restart or Fail-Safe activates fail outputs
// - an activated fail output stays active through Restart into Normal
// - pulse fail output runs at 100 Hz, duty set by pulse_duty_select
// - strap input on pulse pin is filtered for 64 us
// - pulse duty choices are 20, 10, 5 and 2.5 percent, 20 default
// - fail_output_force activates all fail outputs; clearing turns them off unless a failure is latched
module foagc_top
  import foagc_pkg::*;
#(
  parameter int BLINK_CYCLES = foagc_pkg::BLINK_CYC,
  parameter int PULSE_CYCLES = foagc_pkg::PULSE_CYC,
  parameter int STRAP_CYCLES = foagc_pkg::STRAP_FILT_CYC,
  parameter int WAKE_CYCLES  = foagc_pkg::WAKE_FILT_CYC
) (
  input  wire logic                     CLOCK,
  input  wire logic                     RESET,
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [11:0]              PADDR,
  input  wire logic [31:0]              PWDATA,
  output logic      [31:0]              PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR,
  input  wire foagc_pkg::foagc_mode_t   SYS_MODE,
  input  wire logic                     FAIL_EVENT,
  input  wire logic [1:0]               PIN_LEVEL,
  output foagc_pkg::foagc_drive_t       BLINK_DRV,
  output foagc_pkg::foagc_drive_t       PULSE_DRV,
  output logic                          STRAP_LEVEL,
  output logic                          IRQ
);
  import foagc_pkg::*;

  localparam int BW = $clog2(BLINK_CYCLES + 1);
  localparam int PW = $clog2(PULSE_CYCLES + 1);

  foagc_fn_t  blink_fn_r;
  foagc_fn_t  pulse_fn_r;
  logic [1:0] duty_r;
  logic       force_r;
  logic       fail_latched_r;
  logic [1:0] stat_r;
  logic [1:0] stat_nxt;
  logic [1:0] mask_r;
  logic [1:0] level_r;
  logic [1:0] filt;
  logic [1:0] filt_q_r;
  logic [1:0] wake_evt;
  logic [1:0] wake_cap;
  logic       strap_filt;
  logic       fo_active;
  logic       blink_phase;
  logic       pulse_phase;
  logic       acc_done;
  logic       wr_done;
  logic       rd_stat_done;
  logic       mapped;
  logic [31:0] rd_mux;

  function automatic logic [PW-1:0] duty_cycles(input logic [1:0] sel);
    logic [PW-1:0] c;
    c = '0;
    unique case (sel)
      2'h0: c = PW'(PULSE_CYCLES / PERMIL * DUTY_PERMIL_20);
      2'h1: c = PW'(PULSE_CYCLES / PERMIL * DUTY_PERMIL_10);
      2'h2: c = PW'(PULSE_CYCLES / PERMIL * DUTY_PERMIL_5);
      2'h3: c = PW'(PULSE_CYCLES / PERMIL * DUTY_PERMIL_2P5);
    endcase
    return c;
  endfunction : duty_cycles

  function automatic foagc_drive_t drive_of(input foagc_fn_t fn, input foagc_mode_t m,
                                            input logic fail_output_force);
    foagc_drive_t d;
    logic         sw_en;
    sw_en = (m != MODE_RESTART) && (m != MODE_FAILSAFE);
    d     = '{out: 1'b1, oe: 1'b0};
    unique case (fn)
      FN_FAIL: d = '{out: 1'b0, oe: fail_output_force};
      FN_LS:   d = '{out: 1'b0, oe: sw_en};
      FN_HS:   d = '{out: 1'b1, oe: sw_en};
      default: d = '{out: 1'b1, oe: 1'b0};
    endcase
    return d;
  endfunction : drive_of

  assign acc_done     = PSEL && PENABLE && PREADY;
  assign wr_done      = acc_done && PWRITE;
  assign rd_stat_done = acc_done && !PWRITE && (PADDR == STAT_OFS);
  assign mapped       = (PADDR == CTRL_OFS) || (PADDR == STAT_OFS) ||
                        (PADDR == MASK_OFS) || (PADDR == LVL_OFS);

  // apb slave: one wait-free access phase; pready raised from the setup cycle
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= '0;
    end
    else
    begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped;
      if (PSEL && !PENABLE && !PWRITE)
        PRDATA <= rd_mux;
    end
  end

  always_comb
  begin
    rd_mux = '0;
    if (PADDR == CTRL_OFS)
    begin
      rd_mux[CTRL_BLINK_LSB +: 3] = blink_fn_r;
      rd_mux[CTRL_PULSE_LSB +: 3] = pulse_fn_r;
      rd_mux[CTRL_DUTY_LSB +: 2]  = duty_r;
      rd_mux[CTRL_FORCE_BIT]      = force_r;
    end
    else if (PADDR == STAT_OFS)
      rd_mux[1:0] = stat_r;
    else if (PADDR == MASK_OFS)
      rd_mux[1:0] = mask_r;
    else if (PADDR == LVL_OFS)
    begin
      rd_mux[1:0]           = level_r;
      rd_mux[LVL_STRAP_BIT] = strap_filt;
      rd_mux[LVL_FAIL_BIT]  = fo_active;
    end
  end

  // function control
  // settings load only in normal mode, so lower modes run on the last values
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      blink_fn_r <= FN_RESET;
      pulse_fn_r <= FN_RESET;
      duty_r     <= DUTY_RESET;
      force_r    <= 1'b0;
    end
    else if (wr_done && PADDR == CTRL_OFS && SYS_MODE == MODE_NORMAL)
    begin
      blink_fn_r <= foagc_fn_t'(PWDATA[CTRL_BLINK_LSB +: 3]);
      pulse_fn_r <= foagc_fn_t'(PWDATA[CTRL_PULSE_LSB +: 3]);
      duty_r     <= PWDATA[CTRL_DUTY_LSB +: 2];
      force_r    <= PWDATA[CTRL_FORCE_BIT];
    end
  end

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
      mask_r <= '0;
    else if (wr_done && PADDR == MASK_OFS)
      mask_r <= PWDATA[1:0];
  end

  // failure latch
  // set wins over clear; the latch survives restart and normal-mode entry
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
      fail_latched_r <= 1'b0;
    else if (FAIL_EVENT)
      fail_latched_r <= 1'b1;
    else if (wr_done && PADDR == CTRL_OFS && PWDATA[CTRL_FCLR_BIT] &&
             SYS_MODE == MODE_NORMAL)
      fail_latched_r <= 1'b0;
  end

  assign fo_active = fail_latched_r || force_r;

  foagc_pwm #(
    .PERIOD (BLINK_CYCLES),
    .W      (BW)
  ) u_blink (
    .CLOCK  (CLOCK),
    .RESET  (RESET),
    .run    (fo_active),
    .on_cyc (BW'(BLINK_CYCLES / 2)),
    .active (blink_phase)
  );

  foagc_pwm #(
    .PERIOD (PULSE_CYCLES),
    .W      (PW)
  ) u_pulse (
    .CLOCK  (CLOCK),
    .RESET  (RESET),
    .run    (fo_active),
    .on_cyc (duty_cycles(duty_r)),
    .active (pulse_phase)
  );

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      BLINK_DRV <= '{out: 1'b1, oe: 1'b0};
      PULSE_DRV <= '{out: 1'b1, oe: 1'b0};
    end
    else
    begin
      BLINK_DRV <= drive_of(blink_fn_r, SYS_MODE, blink_phase);
      PULSE_DRV <= drive_of(pulse_fn_r, SYS_MODE, pulse_phase);
    end
  end

  foagc_filter #(
    .CNT  (STRAP_CYCLES),
    .INIT (1'b1)
  ) u_strap (
    .CLOCK (CLOCK),
    .RESET (RESET),
    .din   (PIN_LEVEL[1]),
    .q     (strap_filt)
  );

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
      STRAP_LEVEL <= 1'b1;
    else
      STRAP_LEVEL <= strap_filt;
  end

  // wake inputs each get their own filter of WAKE_CYCLES so glitches do not wake
  for (genvar i = 0; i < 2; i++)
  begin : g_wake
    foagc_filter #(
      .CNT  (WAKE_CYCLES),
      .INIT (1'b0)
    ) u_wfilt (
      .CLOCK (CLOCK),
      .RESET (RESET),
      .din   (PIN_LEVEL[i]),
      .q     (filt[i])
    );
  end

  assign wake_cap[0] = blink_fn_r == FN_WAKE && SYS_MODE != MODE_FAILSAFE &&
                       SYS_MODE != MODE_INIT;
  assign wake_cap[1] = pulse_fn_r == FN_WAKE && SYS_MODE != MODE_FAILSAFE &&
                       SYS_MODE != MODE_INIT;

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
      filt_q_r <= '0;
    else
      filt_q_r <= filt;
  end

  // wake event capture
  // either edge wakes; a read clears only bits it returned, and set wins
  assign wake_evt = wake_cap & (filt ^ filt_q_r);
  assign stat_nxt = (stat_r & ~(rd_stat_done ? PRDATA[1:0] : 2'h0)) | wake_evt;

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      stat_r <= '0;
      IRQ    <= 1'b0;
    end
    else
    begin
      stat_r <= stat_nxt;
      IRQ    <= |(stat_nxt & mask_r);
    end
  end

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
      level_r <= '0;
    else
    begin
      level_r[0] <= PIN_LEVEL[0] && blink_fn_r != FN_FAIL && blink_fn_r != FN_OFF &&
                    (SYS_MODE == MODE_NORMAL || SYS_MODE == MODE_STOP);
      level_r[1] <= PIN_LEVEL[1] && pulse_fn_r != FN_FAIL && pulse_fn_r != FN_OFF &&
                    (SYS_MODE == MODE_NORMAL || SYS_MODE == MODE_STOP);
    end
  end

  cfg_hold_a: assert property (@(posedge CLOCK) disable iff (RESET)
    SYS_MODE != MODE_NORMAL |=> $stable(blink_fn_r) && $stable(pulse_fn_r))
    else $error("pin function changed outside normal mode");

  ls_drive_a: assert property (@(posedge CLOCK) disable iff (RESET)
    blink_fn_r == FN_LS && SYS_MODE == MODE_NORMAL |=> BLINK_DRV.oe && !BLINK_DRV.out)
    else $error("low-side pin not driven low");

  hs_drive_a: assert property (@(posedge CLOCK) disable iff (RESET)
    pulse_fn_r == FN_HS && SYS_MODE == MODE_STOP |=> PULSE_DRV.oe && PULSE_DRV.out)
    else $error("high-side pin not driven high");

  sw_off_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (blink_fn_r inside {FN_LS, FN_HS}) &&
    (SYS_MODE inside {MODE_RESTART, MODE_FAILSAFE}) |=> !BLINK_DRV.oe)
    else $error("switch still on in restart or fail-safe");

  wake_latch_a: assert property (@(posedge CLOCK) disable iff (RESET)
    wake_evt[1] |=> stat_r[1] ##1 (stat_r[1] || $past(rd_stat_done)))
    else $error("wake event not latched");

  fail_set_a: assert property (@(posedge CLOCK) disable iff (RESET)
    FAIL_EVENT && !fo_active && pulse_fn_r == FN_FAIL |=> fail_latched_r ##2
      (PULSE_DRV.oe || $past(pulse_fn_r) != FN_FAIL))
    else $error("failure did not activate fail output");

  fail_keep_a: assert property (@(posedge CLOCK) disable iff (RESET)
    fail_latched_r && SYS_MODE == MODE_RESTART |=> fail_latched_r)
    else $error("fail latch lost in restart");

  level_fb_a: assert property (@(posedge CLOCK) disable iff (RESET)
    blink_fn_r == FN_LS && SYS_MODE == MODE_NORMAL |=> level_r[0] == $past(PIN_LEVEL[0]))
    else $error("level feedback mismatch");

  force_on_a: assert property (@(posedge CLOCK) disable iff (RESET)
    $rose(force_r) && !$past(fail_latched_r) |=> blink_phase && pulse_phase)
    else $error("force bit did not activate outputs");

  strap_filt_a: assert property (@(posedge CLOCK) disable iff (RESET)
    $changed(strap_filt) |-> $past(PIN_LEVEL[1]) == strap_filt &&
                             $past(PIN_LEVEL[1], 2) == strap_filt)
    else $error("strap level accepted without filtering");

endmodule : foagc_top

// ===== foagc_pins.sv
// pin-side model: wake switches and drive levels on the two alternate pins
`timescale 1ns/10ps
module foagc_pins
  import foagc_pkg::*;
(
  input  wire foagc_pkg::foagc_drive_t blink_drv,
  input  wire foagc_pkg::foagc_drive_t pulse_drv,
  input  wire logic [1:0]              ext_lvl,
  output logic      [1:0]              pin_lvl
);
  // strap on pin 1 is not held; it follows pulse_drv or ext_lvl[1]
  // a released pin follows its external switch; the bench idles both high
  assign pin_lvl[1] = pulse_drv.oe ? pulse_drv.out : ext_lvl[1];
  assign pin_lvl[0] = blink_drv.oe ? blink_drv.out : ext_lvl[0];
endmodule : foagc_pins

// ===== foagc_top_tb.sv
// self-checking bench for the fail-output / alternate gpio block
`timescale 1ns/10ps
module foagc_top_tb;
  import foagc_pkg::*;
  localparam int BC = 100;
  localparam int PC = 1000;
  logic         CLOCK, RESET, PSEL, PENABLE, PWRITE, FAIL_EVENT;
  logic         PREADY, PSLVERR, STRAP_LEVEL, IRQ, err;
  logic [11:0]  PADDR;
  logic [31:0]  PWDATA, PRDATA, rd;
  logic [1:0]   PIN_LEVEL, ext_lvl;
  foagc_mode_t  SYS_MODE;
  foagc_drive_t BLINK_DRV, PULSE_DRV;
  int           error_cnt = 0;
  int           num_checks = 0;
  int           ctrl_m, stat_m, mask_m, nb, np, g;
  int           duty_q[$] = '{200, 100, 50, 25};

  foagc_top #(.BLINK_CYCLES(BC), .PULSE_CYCLES(PC), .STRAP_CYCLES(8), .WAKE_CYCLES(4)) dut (
    .CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SYS_MODE(SYS_MODE), .FAIL_EVENT(FAIL_EVENT), .PIN_LEVEL(PIN_LEVEL),
    .BLINK_DRV(BLINK_DRV), .PULSE_DRV(PULSE_DRV), .STRAP_LEVEL(STRAP_LEVEL), .IRQ(IRQ));

  foagc_pins pins (.blink_drv(BLINK_DRV), .pulse_drv(PULSE_DRV), .ext_lvl(ext_lvl),
    .pin_lvl(PIN_LEVEL));

  initial
  begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic chk_reg(input string nm, input int exp, input logic [31:0] got);
    num_checks++;
    if (got !== 32'(exp))
    begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk_reg

  task automatic chk_pin(input string nm, input int exp, input logic [31:0] got);
    num_checks++;
    if (got !== 32'(exp))
    begin
      error_cnt++;
      $display("Error %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_pin

  // one apb transfer; waits for pready, the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CLOCK);
      k++;
    end
    while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    chk_pin("pready_wait", 1, k);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input int d);
    apb(1'b1, a, d);
    if (a == CTRL_OFS && SYS_MODE == MODE_NORMAL)
      ctrl_m = d & 32'h0000_1377;
    if (a == MASK_OFS)
      mask_m = d & 3;
  endtask : wr

  task automatic rdc(input logic [11:0] a, input int exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk_reg(nm, exp, rd);
    if (a == STAT_OFS)
      stat_m = 0;
  endtask : rdc

  task automatic mode(input foagc_mode_t m);
    @(posedge CLOCK);
    SYS_MODE <= m;
    repeat (4) @(posedge CLOCK);
  endtask : mode

  task automatic wake(input int b, input logic v);
    @(posedge CLOCK);
    ext_lvl[b] <= v;
    repeat (12) @(posedge CLOCK);
  endtask : wake

  // counts active drive cycles of both pins over a window
  task automatic cnt();
    nb = 0;
    np = 0;
    repeat (PC)
    begin
      @(posedge CLOCK);
      nb += int'(BLINK_DRV.oe === 1'b1);
      np += int'(PULSE_DRV.oe === 1'b1);
    end
  endtask : cnt

  initial
  begin
    #900_000;
    error_cnt++;
    final_report();
  end

  initial
  begin
    g = $urandom(32'h9DAB9D11);
    {PSEL, PENABLE, PWRITE, FAIL_EVENT} = 4'h0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    SYS_MODE = MODE_INIT;
    ext_lvl = 2'h3;
    {ctrl_m, stat_m, mask_m} = {32'h0, 32'h0, 32'h0};
    RESET = 1'b1;
    repeat (5) @(posedge CLOCK);
    RESET <= 1'b0;
    wr(CTRL_OFS, 32'h0000_0062);
    rdc(CTRL_OFS, ctrl_m, "ctrl_init");
    // an idle fail pin is released with its data low
    chk_pin("blink_rst", 0, BLINK_DRV);
    chk_pin("strap_rst", 1, STRAP_LEVEL);
    $display("test reset done");
    mode(MODE_NORMAL);
    wr(CTRL_OFS, 32'h0000_0062);
    rdc(CTRL_OFS, ctrl_m, "ctrl_norm");
    chk_pin("blink_ls", 1, BLINK_DRV);
    chk_pin("pulse_hs", 3, PULSE_DRV);
    rdc(LVL_OFS, 6, "lvl_norm");
    mode(MODE_STOP);
    wr(CTRL_OFS, $urandom & 32'h0000_1377);
    rdc(CTRL_OFS, ctrl_m, "ctrl_stop");
    rdc(LVL_OFS, 6, "lvl_stop");
    chk_pin("pulse_stop", 3, PULSE_DRV);
    mode(MODE_SLEEP);
    chk_pin("blink_sleep", 1, BLINK_DRV);
    mode(MODE_RESTART);
    chk_pin("blink_rst", 0, BLINK_DRV);
    chk_pin("pulse_rst", 2, PULSE_DRV);
    mode(MODE_NORMAL);
    chk_pin("pulse_back", 3, PULSE_DRV);
    rdc(CTRL_OFS, ctrl_m, "ctrl_back");
    apb(1'b0, 12'h010, 32'h0);
    chk_reg("unmapped_rd", 0, rd);
    chk_pin("unmapped_err", 1, err);
    $display("test modes done");
    wr(CTRL_OFS, 32'h0000_0033);
    // releasing the low-side pin lets the high switch raise it: a rising wake edge
    wake(0, 1'b1);
    stat_m = 1;
    chk_pin("irq_masked", 0, IRQ);
    wr(MASK_OFS, 1);
    repeat (2) @(posedge CLOCK);
    chk_pin("irq_on", int'((stat_m & mask_m) != 0), IRQ);
    rdc(STAT_OFS, 1, "stat_blink");
    repeat (2) @(posedge CLOCK);
    chk_pin("irq_off", 0, IRQ);
    mode(MODE_RESTART);
    wake(1, 1'b0);
    mode(MODE_FAILSAFE);
    wake(0, 1'b1);
    wake(0, 1'b0);
    mode(MODE_NORMAL);
    rdc(STAT_OFS, 2, "stat_restart");
    rdc(CTRL_OFS, ctrl_m, "ctrl_wake");
    $display("test wake done");
    wr(CTRL_OFS, 32'h0000_0011);
    ext_lvl <= 2'h3;
    repeat (20) @(posedge CLOCK);
    g = 1 + ($urandom % 6);
    ext_lvl[1] <= 1'b0;
    repeat (g) @(posedge CLOCK);
    ext_lvl[1] <= 1'b1;
    repeat (12) @(posedge CLOCK);
    chk_pin("strap_glitch", 1, STRAP_LEVEL);
    wake(1, 1'b0);
    chk_pin("strap_low", 0, STRAP_LEVEL);
    rdc(LVL_OFS, 0, "lvl_off");
    wake(1, 1'b1);
    $display("test strap done");
    foreach (duty_q[i])
    begin
      wr(CTRL_OFS, 32'h0000_1000 | (i << 8));
      repeat (PC) @(posedge CLOCK);
      cnt();
      chk_pin("pulse_duty", duty_q[i] * PC / 1000, np);
      chk_pin("blink_duty", PC / 2, nb);
    end
    wr(CTRL_OFS, 32'h0000_0000);
    repeat (2) @(posedge CLOCK);
    cnt();
    chk_pin("force_off", 0, np + nb);
    $display("test force done");
    @(posedge CLOCK);
    FAIL_EVENT <= 1'b1;
    SYS_MODE <= MODE_RESTART;
    repeat (10) @(posedge CLOCK);
    cnt();
    chk_pin("fail_pulse", 200 * PC / 1000, np);
    apb(1'b0, LVL_OFS, 32'h0);
    chk_pin("lvl_fail", 1, rd[LVL_FAIL_BIT]);
    FAIL_EVENT <= 1'b0;
    mode(MODE_NORMAL);
    cnt();
    chk_pin("fail_hold", PC / 2, nb);
    rdc(CTRL_OFS, ctrl_m, "ctrl_fail");
    wr(CTRL_OFS, 32'h0000_2000);
    repeat (5) @(posedge CLOCK);
    cnt();
    chk_pin("fail_clr", 0, np + nb);
    $display("test failure done");
    final_report();
  end
endmodule : foagc_top_tb
